// >>> rtl/wdg_top.sv
`timescale 1ns/1ps
`include "wdg_cfg.svh"
// Function
// - Counter advances on ticks of the separate low-frequency oscillator.
// - The restart command clears the counter; software restarts before time-out.
// - Reset and interrupt enables select stopped, interrupt, reset or combined mode.
// - Programmed always-on fuse forces reset mode: reset enable one, interrupt enable zero.
// - One write with change enable clear updates reset enable and period within four cycles.
// - Time-out sets the interrupt flag when interrupt operation is configured.
// - Flag clears when the vector executes or when one is written to it.
// - Interrupt request needs global enable, interrupt enable and pending flag.
// - In combined mode the vector clears interrupt enable and flag.
// - In combined mode an unserviced second time-out issues a system reset.
// - Scan-chain reset sets status bit 4; power-on or writing zero clears it.
// - Watchdog reset sets status bit 3; power-on or writing zero clears it.
// - Brown-out reset sets status bit 2; power-on or writing zero clears it.
// - External pin reset sets status bit 1; power-on or writing zero clears it.
// - Power-on sets status bit 0; only a written zero clears it.
// - Change enable clears itself four clock cycles after being written.
// - While the watchdog reset flag is set, reset enable reads and acts as one.
// - Period codes give 2048 cycles doubling to 1048576; codes above nine are reserved.
// - A reset-mode time-out gives a one-cycle internal reset pulse.
module wdg_top
  import wdg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic osc_clk,
  input wire logic always_on_fuse,
  input wire logic restart_cmd,
  input wire logic irq_ack,
  input wire logic global_irq_en,
  input wire logic pin_reset_evt,
  input wire logic brownout_reset_evt,
  input wire logic scan_reset_evt,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic irq_req,
  output logic timeout_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  wdg_state_t s_q;
  wdg_state_t s_d;
  wdg_ctrl_t wr_val;
  wdg_ctrl_t ctrl_rd;
  logic fuse;
  logic tick;
  logic eff_de;
  logic eff_ie;
  logic running;
  logic wr_ctrl;
  logic wr_cause;
  logic timeout;
  logic timeout_rst;
  logic flag_set;
  logic [20:0] limit;

  always_comb begin
    s_d = s_q;
    wr_val = wdg_ctrl_t'(io_wdata);
    wr_ctrl = io_wr && (io_addr == `WDG_CTRL_ADDR);
    wr_cause = io_wr && (io_addr == `WDG_CAUSE_ADDR);
    // The fuse synchroniser is read at its second stage only; the oscillator one at its second and third stages, for edge detection.
    s_d.osc_sync = {s_q.osc_sync[1:0], osc_clk};
    s_d.fuse_sync = {s_q.fuse_sync[0], always_on_fuse};
    fuse = s_q.fuse_sync[1];
    tick = s_q.osc_sync[1] && !s_q.osc_sync[2];
    eff_de = fuse || s_q.rst_en || s_q.cause[`WDG_CAUSE_TIMEOUT];
    eff_ie = !fuse && s_q.irq_en;
    running = eff_de || eff_ie;
    // Reserved codes behave as the longest period rather than wrapping short.
    if (s_q.period > `WDG_PERIOD_MAX) begin
      limit = `WDG_BASE_CYCLES << `WDG_PERIOD_MAX;
    end else begin
      limit = `WDG_BASE_CYCLES << s_q.period;
    end
    timeout = running && tick && ({1'b0, s_q.count} == limit - 21'h000001);

    // Counter.
    if (restart_cmd || !running) begin
      s_d.count = 20'h00000;
    end else if (tick) begin
      if (timeout) begin
        s_d.count = 20'h00000;
      end else begin
        s_d.count = s_q.count + 20'h00001;
      end
    end

    // Time-out action.
    flag_set = timeout && eff_ie && (!eff_de || !s_q.irq_flag);
    timeout_rst = timeout && eff_de && (!eff_ie || s_q.irq_flag);
    s_d.rst_pulse = timeout_rst;

    // Unlock window ages out even if no write arrives.
    if (s_q.lock == WDG_UNLOCKED) begin
      if (s_q.win_cnt > 3'h1) begin
        s_d.win_cnt = s_q.win_cnt - 3'h1;
      end else begin
        s_d.lock = WDG_LOCKED;
        s_d.win_cnt = 3'h0;
      end
    end

    if (irq_ack) begin
      s_d.irq_flag = 1'b0;
      if (eff_de) begin
        s_d.irq_en = 1'b0;
      end
    end

    if (wr_ctrl) begin
      s_d.irq_en = wr_val.irq_en;
      if (wr_val.irq_flag) begin
        s_d.irq_flag = 1'b0;
      end
      if (wr_val.change_en && wr_val.rst_en) begin
        s_d.lock = WDG_UNLOCKED;
        s_d.win_cnt = `WDG_UNLOCK_CYCLES;
        s_d.rst_en = 1'b1;
      end else if ((s_q.lock == WDG_UNLOCKED) && !wr_val.change_en) begin
        s_d.rst_en = wr_val.rst_en;
        s_d.period = {wr_val.period_hi, wr_val.period_lo};
        s_d.lock = WDG_LOCKED;
        s_d.win_cnt = 3'h0;
      end else begin
        s_d.rst_en = s_q.rst_en || wr_val.rst_en;
      end
    end

    // Set wins over any clear in the same cycle.
    if (flag_set) begin
      s_d.irq_flag = 1'b1;
    end
    if (s_q.cause[`WDG_CAUSE_TIMEOUT]) begin
      s_d.rst_en = 1'b1;
    end

    // Reset cause flags: writing zero clears, events set.
    if (wr_cause) begin
      s_d.cause = s_q.cause & io_wdata[4:0];
    end
    if (scan_reset_evt) begin
      s_d.cause[`WDG_CAUSE_SCAN] = 1'b1;
    end
    if (timeout_rst) begin
      s_d.cause[`WDG_CAUSE_TIMEOUT] = 1'b1;
    end
    if (brownout_reset_evt) begin
      s_d.cause[`WDG_CAUSE_BROWNOUT] = 1'b1;
    end
    if (pin_reset_evt) begin
      s_d.cause[`WDG_CAUSE_PIN] = 1'b1;
    end

    ctrl_rd.irq_flag = s_q.irq_flag;
    ctrl_rd.irq_en = eff_ie;
    ctrl_rd.period_hi = s_q.period[3];
    ctrl_rd.change_en = (s_q.lock == WDG_UNLOCKED);
    ctrl_rd.rst_en = eff_de;
    ctrl_rd.period_lo = s_q.period[2:0];
    if (io_rd && (io_addr == `WDG_CTRL_ADDR)) begin
      s_d.rdata = ctrl_rd;
    end else if (io_rd && (io_addr == `WDG_CAUSE_ADDR)) begin
      s_d.rdata = {3'h0, s_q.cause};
    end else if (io_rd) begin
      s_d.rdata = 8'h00;
    end
  end

  // Power-on is this reset; only the power-on cause bit comes up set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.lock <= WDG_LOCKED;
      s_q.cause <= `WDG_CAUSE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign io_rdata = s_q.rdata;
  assign irq_req = global_irq_en && eff_ie && s_q.irq_flag;
  assign timeout_reset_pulse = s_q.rst_pulse;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence unlock_write_s;
    wr_ctrl && wr_val.change_en && wr_val.rst_en;
  endsequence

  sequence quiet_window_s;
    (!wr_ctrl) [*4];
  endsequence

  sequence irq_only_timeout_s;
    timeout && eff_ie && !eff_de;
  endsequence

  sequence reset_only_timeout_s;
    timeout && eff_de && !eff_ie;
  endsequence

  count_steps_a: assert property ((s_q.count != $past(s_q.count)) |-> ($past(tick) || s_q.count == 20'h00000))
    else $error("counter moved without an oscillator tick");
  restart_clears_a: assert property (restart_cmd |=> s_q.count == 20'h00000)
    else $error("restart did not clear the counter");
  stopped_idle_a: assert property (!running |=> (s_q.count == 20'h00000) && !s_q.rst_pulse)
    else $error("stopped watchdog counted or reset");
  fuse_forces_a: assert property (fuse |-> ctrl_rd.rst_en && !ctrl_rd.irq_en)
    else $error("fuse did not force reset mode");
  window_closes_a: assert property ((unlock_write_s ##1 quiet_window_s) |=> s_q.lock == WDG_LOCKED)
    else $error("change enable stayed set past four cycles");
  window_open_a: assert property (unlock_write_s |=> s_q.lock == WDG_UNLOCKED)
    else $error("unlock write did not open the window");
  locked_period_a: assert property ((s_q.lock == WDG_LOCKED) |=> $stable(s_q.period))
    else $error("period changed while locked");
  flag_sets_a: assert property ((timeout && eff_ie && !eff_de) |=> s_q.irq_flag)
    else $error("time-out did not set the interrupt flag");
  vector_clears_a: assert property ((irq_ack && eff_de && !flag_set && !wr_ctrl) |=> !s_q.irq_en && !s_q.irq_flag)
    else $error("vector did not drop to reset mode");
  second_timeout_a: assert property ((timeout && eff_de && eff_ie && s_q.irq_flag) |=> s_q.rst_pulse)
    else $error("unserviced second time-out gave no reset");
  pulse_single_a: assert property (s_q.rst_pulse |-> s_q.cause[`WDG_CAUSE_TIMEOUT] ##1 !s_q.rst_pulse)
    else $error("reset pulse too long or cause not recorded");
  cause_forces_a: assert property (s_q.cause[`WDG_CAUSE_TIMEOUT] |-> ctrl_rd.rst_en)
    else $error("reset enable clear while watchdog cause set");

  // Clears are checked only where no set competes in the same cycle, since sets win.
  // The raw write data is sampled, not the decoded struct, so these stay independent of the decode.
  flag_write_clr_a: assert property (
    wr_ctrl && io_wdata[7] && !flag_set |=> !s_q.irq_flag)
    else $error("writing one did not clear the interrupt flag");
  ack_clears_flag_a: assert property (
    irq_ack && !flag_set && !wr_ctrl |=> !s_q.irq_flag)
    else $error("vector did not clear the interrupt flag");
  irq_gated_a: assert property (
    irq_req |-> global_irq_en && eff_ie && s_q.irq_flag)
    else $error("interrupt request without all enables and flag");
  window_write_a: assert property (
    (s_q.lock == WDG_UNLOCKED) && wr_ctrl && !io_wdata[4] |=> s_q.period == {$past(io_wdata[5]), $past(io_wdata[2:0])})
    else $error("window write did not update the period");
  locked_rst_en_a: assert property (
    (s_q.lock == WDG_LOCKED) && s_q.rst_en |=> s_q.rst_en)
    else $error("reset enable cleared while locked");
  set_rst_any_a: assert property (
    wr_ctrl && io_wdata[3] |=> s_q.rst_en)
    else $error("writing one did not set reset enable");
  irq_en_free_a: assert property (
    wr_ctrl |=> s_q.irq_en == $past(io_wdata[6]))
    else $error("interrupt enable write not taken");
  scan_cause_a: assert property (
    scan_reset_evt |=> s_q.cause[`WDG_CAUSE_SCAN])
    else $error("scan reset cause not recorded");
  brownout_cause_a: assert property (
    brownout_reset_evt |=> s_q.cause[`WDG_CAUSE_BROWNOUT])
    else $error("brown-out cause not recorded");
  pin_cause_a: assert property (
    pin_reset_evt |=> s_q.cause[`WDG_CAUSE_PIN])
    else $error("pin reset cause not recorded");
  por_write_clr_a: assert property (
    wr_cause && !io_wdata[`WDG_CAUSE_POR] |=> !s_q.cause[`WDG_CAUSE_POR])
    else $error("writing zero did not clear the power-on cause");
  por_sticky_a: assert property (
    s_q.cause[`WDG_CAUSE_POR] && !wr_cause |=> s_q.cause[`WDG_CAUSE_POR])
    else $error("power-on cause cleared without a write");
  timeout_reset_a: assert property (
    reset_only_timeout_s |=> s_q.rst_pulse)
    else $error("reset-mode time-out gave no reset pulse");
  irq_only_a: assert property (
    irq_only_timeout_s |=> !s_q.rst_pulse && s_q.irq_flag)
    else $error("interrupt-mode time-out reset the system");
  fuse_no_irq_a: assert property (
    fuse && !s_q.irq_flag |=> !s_q.irq_flag)
    else $error("interrupt flag set while fuse forces reset mode");
  tick_single_a: assert property (
    tick |=> !tick)
    else $error("one oscillator edge gave two ticks");

endmodule : wdg_top

// >>> rtl/wdg_cfg.svh
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH

`define WDG_CTRL_ADDR 8'h60
`define WDG_CAUSE_ADDR 8'h54
`define WDG_UNLOCK_CYCLES 3'h4
`define WDG_BASE_CYCLES 21'h00800
`define WDG_PERIOD_MAX 4'h9
`define WDG_CTRL_RESET 8'h00
`define WDG_CAUSE_RESET 5'h01
`define WDG_CAUSE_POR 0
`define WDG_CAUSE_PIN 1
`define WDG_CAUSE_BROWNOUT 2
`define WDG_CAUSE_TIMEOUT 3
`define WDG_CAUSE_SCAN 4

`endif

// >>> rtl/wdg_pkg.sv
package wdg_pkg;

  typedef enum logic {WDG_LOCKED, WDG_UNLOCKED} wdg_lock_t;

  // Bit order of the control register, bit 7 first.
  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic period_hi;
    logic change_en;
    logic rst_en;
    logic [2:0] period_lo;
  } wdg_ctrl_t;

  typedef struct packed {
    logic [2:0] osc_sync;
    logic [1:0] fuse_sync;
    logic irq_flag;
    logic irq_en;
    logic rst_en;
    logic [3:0] period;
    wdg_lock_t lock;
    logic [2:0] win_cnt;
    logic [19:0] count;
    logic [4:0] cause;
    logic rst_pulse;
    logic [7:0] rdata;
  } wdg_state_t;

endpackage : wdg_pkg

// >>> testbench/test_wdg_top.sv
`timescale 1ns/1ps
`include "wdg_cfg.svh"
module test_wdg_top;
  import wdg_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, osc_clk = 1'b0, always_on_fuse = 1'b0, restart_cmd = 1'b0;
  logic irq_ack = 1'b0, global_irq_en = 1'b0, pin_reset_evt = 1'b0, brownout_reset_evt = 1'b0;
  logic scan_reset_evt = 1'b0, io_wr = 1'b0, io_rd = 1'b0, irq_req, timeout_reset_pulse;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata;
  logic osc_run = 1'b0;
  logic [31:0] rng = 32'hb8701cfb;
  logic [3:0] per;
  logic rbit;
  int bad_count = 0, checked = 0, ticks = 0, cyc = 0;
  wdg_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .osc_clk(osc_clk), .always_on_fuse(always_on_fuse),
    .restart_cmd(restart_cmd), .irq_ack(irq_ack), .global_irq_en(global_irq_en),
    .pin_reset_evt(pin_reset_evt), .brownout_reset_evt(brownout_reset_evt), .scan_reset_evt(scan_reset_evt),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .irq_req(irq_req), .timeout_reset_pulse(timeout_reset_pulse));
  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 sys_clk = ~sys_clk;
  // The oscillator stands still while no time-out is wanted, so reset mode never fires by accident.
  always #50 if (osc_run) osc_clk = ~osc_clk;
  always @(posedge osc_clk) ticks++;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] ctrl_exp(input logic f, input logic ie, input logic re, input logic [3:0] p);
    return {f, ie, p[3], 1'b0, re, p[2:0]};
  endfunction : ctrl_exp
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge sys_clk) #1;
    io_wr = 1'b0;
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge sys_clk) #1;
    io_rd = 1'b0;
    chk(nm, exp, io_rdata);
  endtask : rd
  task automatic pulse(ref logic s);
    @(posedge sys_clk) #1;
    s = 1'b1;
    @(posedge sys_clk) #1;
    s = 1'b0;
  endtask : pulse
  // Waits a bounded time for the interrupt request (sel 0) or the reset pulse (sel 1).
  task automatic wait_out(input logic sel, input string nm);
    int n;
    n = 0;
    while ((sel ? timeout_reset_pulse : irq_req) !== 1'b1 && n < 12000) begin
      @(posedge sys_clk) #1;
      n++;
    end
    chk(nm, 8'h01, {7'h00, sel ? timeout_reset_pulse : irq_req});
  endtask : wait_out
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    rd("ctrl reset", `WDG_CTRL_ADDR, 8'h00);
    rd("cause reset", `WDG_CAUSE_ADDR, 8'h01);
    rng = xs(rng);
    wr(8'h33, rng[7:0]);
    rd("unmapped", 8'h33, 8'h00);
    $display("test reset values done");
    pulse(pin_reset_evt);
    pulse(brownout_reset_evt);
    pulse(scan_reset_evt);
    rd("cause set", `WDG_CAUSE_ADDR, 8'h17);
    wr(`WDG_CAUSE_ADDR, 8'h1d);
    rd("cause clear pin", `WDG_CAUSE_ADDR, 8'h15);
    wr(`WDG_CAUSE_ADDR, 8'h00);
    rd("cause clear all", `WDG_CAUSE_ADDR, 8'h00);
    $display("test reset causes done");
    wr(`WDG_CTRL_ADDR, 8'h08);
    wr(`WDG_CTRL_ADDR, 8'h21);
    rd("locked write", `WDG_CTRL_ADDR, 8'h08);
    per = 4'h0;
    for (int i = 0; i < 5; i++) begin
      rng = xs(rng);
      per = (i == 0) ? 4'h9 : 4'(rng[7:4] % 10);
      rbit = rng[0];
      pulse(restart_cmd);
      wr(`WDG_CTRL_ADDR, 8'h18);
      wr(`WDG_CTRL_ADDR, ctrl_exp(1'b0, 1'b0, rbit, per));
      rd("window write", `WDG_CTRL_ADDR, ctrl_exp(1'b0, 1'b0, rbit, per));
    end
    wr(`WDG_CTRL_ADDR, 8'h08);
    wr(`WDG_CTRL_ADDR, 8'h18);
    rd("change enable open", `WDG_CTRL_ADDR, ctrl_exp(1'b0, 1'b0, 1'b1, per) | 8'h10);
    repeat (4) @(posedge sys_clk);
    rd("change enable closed", `WDG_CTRL_ADDR, ctrl_exp(1'b0, 1'b0, 1'b1, per));
    wr(`WDG_CTRL_ADDR, 8'h00);
    rd("late write", `WDG_CTRL_ADDR, ctrl_exp(1'b0, 1'b0, 1'b1, per));
    wr(`WDG_CTRL_ADDR, 8'h18);
    wr(`WDG_CTRL_ADDR, 8'h00);
    rd("stopped", `WDG_CTRL_ADDR, 8'h00);
    $display("test protected change done");
    wr(`WDG_CTRL_ADDR, 8'h40);
    global_irq_en = 1'b1;
    osc_run = 1'b1;
    pulse(restart_cmd);
    ticks = 0;
    while (ticks < 1500 && cyc < 70000) @(posedge sys_clk) #1;
    chk("early irq", 8'h00, {7'h00, irq_req});
    pulse(restart_cmd);
    ticks = 0;
    wait_out(1'b0, "irq raised");
    chk("period ticks", 8'h01, {7'h00, ticks >= 2047 && ticks <= 2050});
    rd("flag set", `WDG_CTRL_ADDR, 8'hc0);
    global_irq_en = 1'b0;
    #1 chk("irq masked", 8'h00, {7'h00, irq_req});
    global_irq_en = 1'b1;
    wr(`WDG_CTRL_ADDR, 8'hc0);
    rd("flag write clear", `WDG_CTRL_ADDR, 8'h40);
    chk("irq gone", 8'h00, {7'h00, irq_req});
    $display("test interrupt mode done");
    wr(`WDG_CTRL_ADDR, 8'h48);
    pulse(restart_cmd);
    wait_out(1'b0, "combined irq");
    pulse(irq_ack);
    rd("vector clears", `WDG_CTRL_ADDR, 8'h08);
    wait_out(1'b1, "reset pulse");
    @(posedge sys_clk) #1;
    chk("pulse width", 8'h00, {7'h00, timeout_reset_pulse});
    rd("timeout cause", `WDG_CAUSE_ADDR, 8'h08);
    wr(`WDG_CTRL_ADDR, 8'h48);
    wait_out(1'b0, "second combined irq");
    wait_out(1'b1, "unserviced reset");
    osc_run = 1'b0;
    wr(`WDG_CTRL_ADDR, 8'h18);
    wr(`WDG_CTRL_ADDR, 8'h80);
    rd("enable forced", `WDG_CTRL_ADDR, 8'h08);
    wr(`WDG_CAUSE_ADDR, 8'h00);
    wr(`WDG_CTRL_ADDR, 8'h18);
    wr(`WDG_CTRL_ADDR, 8'h00);
    rd("enable released", `WDG_CTRL_ADDR, 8'h00);
    $display("test combined mode done");
    always_on_fuse = 1'b1;
    repeat (4) @(posedge sys_clk);
    rd("fuse forces", `WDG_CTRL_ADDR, 8'h08);
    wr(`WDG_CTRL_ADDR, 8'h40);
    rd("fuse blocks irq", `WDG_CTRL_ADDR, 8'h08);
    $display("test fuse done");
    conclude();
  end
endmodule : test_wdg_top
